// file: hdl/tws_slave.sv
// Overview of operation
// - first byte after start holds seven address bits then direction bit.
// - direction bit one means read, zero means write.
// - acknowledge a matching address on ninth pulse, else ignore transfer.
// - address is 100110 plus the address select pin as lowest bit.
// - data falling while clock high is a start of a new transfer.
// - data rising while clock high is a stop ending any sequence.
// - data changes only while clock low; changes while high are conditions.
// - every byte shifts most significant bit first.
// - first write byte sets the pointer, next byte writes that register.
// - pointer advances by one after each written byte.
// - pointer saturates at 0x1E and never wraps.
// - no acknowledge for a received pointer above 0x1E.
// - on a withheld acknowledge the data line stays released.
// - master not acknowledging ends the read and releases the line.
// - reads start at the loaded pointer and advance after each byte.
// - start without stop is a repeated start and is accepted.
// - device only pulls data low or releases it, never drives high.
`timescale 1ns/1ps
`default_nettype none
module tws_slave (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic address_select_pin,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output logic busy
);
   // ****************************************************************
   // line conditioning
   // ****************************************************************
   tws_line_if line ();

   tws_line_cond u_cond (
      .clk(clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .address_select_pin(address_select_pin),
      .line(line)
   );

   // ****************************************************************
   // state
   // ****************************************************************
   tws_pkg::tws_state_t state_reg;
   tws_pkg::tws_state_t state_next;
   logic [3:0] bitcnt_reg;
   logic [3:0] bitcnt_next;
   logic [7:0] rx_reg;
   logic [7:0] rx_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic rw_reg;
   logic rw_next;
   logic mack_reg;
   logic mack_next;
   logic oe_reg;
   logic oe_next;
   logic wr_reg;
   logic wr_next;
   logic rd_reg;
   logic rd_next;
   logic [7:0] wdata_reg;
   logic [7:0] wdata_next;
   logic addr_match;
   logic byte_in;

   function automatic logic [7:0] ptr_step(input logic [7:0] p);
      if (p >= tws_pkg::PTR_MAX) begin
         ptr_step = tws_pkg::PTR_MAX;
      end else begin
         ptr_step = p + 8'h01;
      end
   endfunction

   assign addr_match = (rx_reg[7:1] == {tws_pkg::ADDR_UPPER,
      line.addr_sel});
   assign byte_in = line.scl_fall && (bitcnt_reg == tws_pkg::BITS_PER_BYTE);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      bitcnt_next = bitcnt_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      mack_next = mack_reg;
      oe_next = oe_reg;
      wr_next = 1'b0;
      rd_next = 1'b0;
      wdata_next = wdata_reg;
      if (line.start) begin
         state_next = tws_pkg::TWS_ADDR;
         bitcnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (line.stop) begin
         state_next = tws_pkg::TWS_IDLE;
         oe_next = 1'b0;
      end else begin
         if (line.scl_rise) begin
            case (state_reg)
               tws_pkg::TWS_ADDR, tws_pkg::TWS_PTR,
               tws_pkg::TWS_WDATA: begin
                  rx_next = {rx_reg[6:0], line.sda_level};
                  bitcnt_next = bitcnt_reg + 4'h1;
               end
               tws_pkg::TWS_RDATA_ACK: begin
                  mack_next = (line.sda_level == tws_pkg::SDA_LOW);
               end
               default: begin
               end
            endcase
         end
         if (line.scl_fall) begin
            case (state_reg)
               tws_pkg::TWS_ADDR: begin
                  if (byte_in) begin
                     if (addr_match) begin
                        oe_next = 1'b1;
                        rw_next = (rx_reg[0] == tws_pkg::RW_READ);
                        state_next = tws_pkg::TWS_ADDR_ACK;
                     end else begin
                        state_next = tws_pkg::TWS_IDLE;
                     end
                  end
               end
               tws_pkg::TWS_ADDR_ACK: begin
                  bitcnt_next = 4'h0;
                  if (rw_reg) begin
                     tx_next = reg_rdata;
                     rd_next = 1'b1;
                     oe_next = ~reg_rdata[7];
                     state_next = tws_pkg::TWS_RDATA;
                  end else begin
                     oe_next = 1'b0;
                     state_next = tws_pkg::TWS_PTR;
                  end
               end
               tws_pkg::TWS_PTR: begin
                  if (byte_in) begin
                     if (rx_reg <= tws_pkg::PTR_MAX) begin
                        ptr_next = rx_reg;
                        oe_next = 1'b1;
                        state_next = tws_pkg::TWS_PTR_ACK;
                     end else begin
                        oe_next = 1'b0;
                        state_next = tws_pkg::TWS_IDLE;
                     end
                  end
               end
               tws_pkg::TWS_WDATA: begin
                  if (byte_in) begin
                     wdata_next = rx_reg;
                     wr_next = 1'b1;
                     oe_next = 1'b1;
                     state_next = tws_pkg::TWS_WDATA_ACK;
                  end
               end
               tws_pkg::TWS_PTR_ACK: begin
                  oe_next = 1'b0;
                  bitcnt_next = 4'h0;
                  state_next = tws_pkg::TWS_WDATA;
               end
               tws_pkg::TWS_WDATA_ACK: begin
                  oe_next = 1'b0;
                  bitcnt_next = 4'h0;
                  ptr_next = ptr_step(ptr_reg);
                  state_next = tws_pkg::TWS_WDATA;
               end
               tws_pkg::TWS_RDATA: begin
                  if (bitcnt_reg == tws_pkg::LAST_TX_BIT) begin
                     oe_next = 1'b0;
                     ptr_next = ptr_step(ptr_reg);
                     state_next = tws_pkg::TWS_RDATA_ACK;
                  end else begin
                     tx_next = {tx_reg[6:0], 1'b0};
                     oe_next = ~tx_reg[6];
                     bitcnt_next = bitcnt_reg + 4'h1;
                  end
               end
               tws_pkg::TWS_RDATA_ACK: begin
                  bitcnt_next = 4'h0;
                  if (mack_reg) begin
                     tx_next = reg_rdata;
                     rd_next = 1'b1;
                     oe_next = ~reg_rdata[7];
                     state_next = tws_pkg::TWS_RDATA;
                  end else begin
                     oe_next = 1'b0;
                     state_next = tws_pkg::TWS_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // sequencing registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= tws_pkg::TWS_IDLE;
         bitcnt_reg <= 4'h0;
         rw_reg <= 1'b0;
         mack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bitcnt_reg <= bitcnt_next;
         rw_reg <= rw_next;
         mack_reg <= mack_next;
      end
   end

   // ****************************************************************
   // data path registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= tws_pkg::PTR_RESET;
         wdata_reg <= 8'h00;
      end else begin
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         wdata_reg <= wdata_next;
      end
   end

   // ****************************************************************
   // pin and strobe outputs
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         oe_reg <= 1'b0;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         oe_reg <= oe_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   assign sda_out = tws_pkg::SDA_LOW;
   assign sda_oe = oe_reg;
   assign reg_addr = ptr_reg;
   assign reg_wdata = wdata_reg;
   assign reg_wr = wr_reg;
   assign reg_rd = rd_reg;
   assign busy = (state_reg != tws_pkg::TWS_IDLE);

   // ****************************************************************
   // checks
   // ****************************************************************
   logic quiet;
   assign quiet = !line.start && !line.stop;

   sequence s_addr_done;
      state_reg == tws_pkg::TWS_ADDR && byte_in && quiet;
   endsequence

   sequence s_ptr_done;
      state_reg == tws_pkg::TWS_PTR && byte_in && quiet;
   endsequence

   sequence s_wbyte_done;
      state_reg == tws_pkg::TWS_WDATA && byte_in && quiet;
   endsequence

   chk_start_abort: assert property (@(posedge clk) disable iff (reset)
      line.start |=> state_reg == tws_pkg::TWS_ADDR && !sda_oe &&
         bitcnt_reg == 4'h0)
      else $error("start did not restart address phase");

   chk_stop_idle: assert property (@(posedge clk) disable iff (reset)
      line.stop && !line.start |=> state_reg == tws_pkg::TWS_IDLE && !sda_oe)
      else $error("stop did not end sequence");

   chk_addr_ack: assert property (@(posedge clk) disable iff (reset)
      s_addr_done and addr_match |=> sda_oe &&
         state_reg == tws_pkg::TWS_ADDR_ACK)
      else $error("matching address not acknowledged");

   chk_addr_ignore: assert property (@(posedge clk) disable iff (reset)
      s_addr_done and !addr_match |=> !sda_oe &&
         state_reg == tws_pkg::TWS_IDLE)
      else $error("foreign address not ignored");

   chk_ptr_range: assert property (@(posedge clk) disable iff (reset)
      s_ptr_done and rx_reg > tws_pkg::PTR_MAX |=> !sda_oe &&
         state_reg == tws_pkg::TWS_IDLE && $stable(ptr_reg))
      else $error("out of range pointer acknowledged");

   chk_ptr_sat: assert property (@(posedge clk) disable iff (reset)
      ptr_reg <= tws_pkg::PTR_MAX)
      else $error("pointer above top register");

   chk_wr_strobe: assert property (@(posedge clk) disable iff (reset)
      s_wbyte_done |=> reg_wr && reg_wdata == $past(rx_reg) &&
         reg_addr == $past(ptr_reg) ##1 !reg_wr)
      else $error("write strobe wrong");

   chk_ptr_step: assert property (@(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_WDATA_ACK && line.scl_fall && quiet |=>
         ptr_reg == ptr_step($past(ptr_reg)))
      else $error("pointer did not advance");

   chk_read_end: assert property (@(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_RDATA_ACK && line.scl_fall && quiet &&
         !mack_reg |=> !sda_oe && state_reg == tws_pkg::TWS_IDLE)
      else $error("read not ended on missing acknowledge");

   chk_read_msb: assert property (@(posedge clk) disable iff (reset)
      reg_rd |-> state_reg == tws_pkg::TWS_RDATA &&
         sda_oe == ~tx_reg[7] && tx_reg == $past(reg_rdata))
      else $error("read byte not loaded msb first");

   chk_oe_quiet: assert property (@(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_IDLE |-> !sda_oe && sda_out == 1'b0)
      else $error("data line held while idle");
endmodule
`default_nettype wire

// file: hdl/tws_pkg.sv
package tws_pkg;
   // ****************************************************************
   // slave address and register space
   // ****************************************************************
   localparam logic [5:0] ADDR_UPPER = 6'h26;
   localparam logic [7:0] PTR_MAX = 8'h1e;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   localparam logic RW_READ = 1'b1;
   localparam logic SDA_LOW = 1'b0;

   // ****************************************************************
   // port states
   // ****************************************************************
   typedef enum logic [3:0] {
      TWS_IDLE,
      TWS_ADDR,
      TWS_ADDR_ACK,
      TWS_PTR,
      TWS_PTR_ACK,
      TWS_WDATA,
      TWS_WDATA_ACK,
      TWS_RDATA,
      TWS_RDATA_ACK
   } tws_state_t;
endpackage

// file: hdl/tws_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tws_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda_level;
   logic addr_sel;
   modport cond (output scl_rise, scl_fall, start, stop, sda_level,
      addr_sel);
   modport port (input scl_rise, scl_fall, start, stop, sda_level,
      addr_sel);
endinterface
`default_nettype wire

// file: hdl/tws_line_cond.sv
`timescale 1ns/1ps
`default_nettype none
module tws_line_cond (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic address_select_pin,
   tws_line_if.cond line
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic scl_meta_reg;
   logic scl_sync_reg;
   logic scl_prev_reg;
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic sda_prev_reg;
   logic sel_meta_reg;
   logic sel_sync_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
      end else begin
         sel_meta_reg <= address_select_pin;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // ****************************************************************
   // line events
   // ****************************************************************
   assign line.scl_rise = scl_sync_reg & ~scl_prev_reg;
   assign line.scl_fall = ~scl_sync_reg & scl_prev_reg;
   // data edge while clock stays high
   assign line.start = scl_sync_reg & scl_prev_reg & sda_prev_reg &
      ~sda_sync_reg;
   assign line.stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
      sda_sync_reg;
   assign line.sda_level = sda_sync_reg;
   assign line.addr_sel = sel_sync_reg;
endmodule
`default_nettype wire

// file: sim/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   input wire logic clk,
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // ****************************************************************
   // bus master, drives clock and pulls data low only
   // ****************************************************************
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one bit: data set while clock low, sampled while clock high
   task automatic put_bit(input logic b, output logic seen);
      tick(3);
      sda_low = !b;
      tick(5);
      scl = 1'b1;
      tick(5);
      seen = sda;
      tick(5);
      scl = 1'b0;
   endtask

   // also serves as repeated start
   task automatic start();
      tick(6);
      sda_low = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_low = 1'b1;
      tick(5);
      scl = 1'b0;
   endtask

   task automatic stop();
      tick(6);
      sda_low = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_low = 1'b0;
      tick(5);
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
      end
      put_bit(1'b1, s);
      ack = !s;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, d[i]);
      end
      put_bit(!ack, s);
   endtask
endmodule
`default_nettype wire

// file: sim/two_wire_register_slave_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_register_slave_port_tb_top;
   logic clk, reset, scl, m_low, sda, address_select_pin;
   logic sda_out, sda_oe, reg_wr, reg_rd, busy, ack;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [7:0] mem [0:31];
   int failures, tests_run, wr_count, rd_count, base;

   // ****************************************************************
   // wired data line with pull-up, register array
   // ****************************************************************
   assign sda = !(m_low || (sda_oe && !sda_out));
   assign reg_rdata = mem[reg_addr[4:0]];

   tws_slave tws_slave_inst (
      .clk(clk),
      .reset(reset),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .address_select_pin(address_select_pin),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .busy(busy)
   );

   tws_master_model tws_master_model_inst (
      .clk(clk),
      .scl(scl),
      .sda_low(m_low),
      .sda(sda)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (reg_wr === 1'b1) begin
         mem[reg_addr[4:0]] <= reg_wdata;
         wr_count <= wr_count + 1;
      end
      if (reg_rd === 1'b1) begin
         rd_count <= rd_count + 1;
      end
      if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
         $display("Error at %0t: sda_out %h expected %h", $time,
            sda_out, 1'b0);
         failures++;
      end
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic wr(input logic [7:0] b, input logic exp_ack);
      tws_master_model_inst.write_byte(b, ack);
      check({7'h00, ack}, {7'h00, exp_ack});
   endtask

   task automatic rd(input logic m_ack, input logic [7:0] exp);
      tws_master_model_inst.read_byte(m_ack, d);
      check(d, exp);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      check({7'h00, busy}, 8'h00);
      check({7'h00, sda_oe}, 8'h00);
      check({7'h00, reg_wr}, 8'h00);
      check({7'h00, reg_rd}, 8'h00);
      check(reg_wdata, 8'h00);
      check(reg_addr, 8'h00);
      $display("t_reset done");
   endtask

   task automatic t_write();
      tws_master_model_inst.start();
      wr(8'h98, 1'b1);
      wr(8'h1c, 1'b1);
      wr(8'ha5, 1'b1);
      wr(8'h5a, 1'b1);
      wr(8'hc3, 1'b1);
      wr(8'h77, 1'b1);
      tws_master_model_inst.stop();
      check(mem[28], 8'ha5);
      check(mem[29], 8'h5a);
      check(mem[30], 8'h77);
      check(8'(wr_count), 8'h04);
      check(reg_addr, 8'h1e);
      $display("t_write done");
   endtask

   task automatic t_bad_ptr();
      base = wr_count;
      tws_master_model_inst.start();
      wr(8'h98, 1'b1);
      wr(8'h1f, 1'b0);
      check({7'h00, busy}, 8'h00);
      tws_master_model_inst.stop();
      check(reg_addr, 8'h1e);
      check(8'(wr_count - base), 8'h00);
      $display("t_bad_ptr done");
   endtask

   task automatic t_select();
      address_select_pin = 1'b1;
      tws_master_model_inst.start();
      wr(8'h98, 1'b0);
      check({7'h00, busy}, 8'h00);
      wr(8'h05, 1'b0);
      tws_master_model_inst.stop();
      tws_master_model_inst.start();
      wr(8'h9a, 1'b1);
      wr(8'h05, 1'b1);
      wr(8'h3c, 1'b1);
      tws_master_model_inst.stop();
      check(mem[5], 8'h3c);
      $display("t_select done");
   endtask

   task automatic t_read();
      base = rd_count;
      tws_master_model_inst.start();
      wr(8'h9a, 1'b1);
      wr(8'h1c, 1'b1);
      tws_master_model_inst.start();
      wr(8'h9b, 1'b1);
      rd(1'b1, 8'ha5);
      rd(1'b1, 8'h5a);
      rd(1'b1, 8'h77);
      rd(1'b0, 8'h77);
      tws_master_model_inst.tick(4);
      check({7'h00, sda_oe}, 8'h00);
      check({7'h00, busy}, 8'h00);
      check(8'(rd_count - base), 8'h04);
      tws_master_model_inst.stop();
      $display("t_read done");
   endtask

   task automatic t_abort();
      logic s;
      base = wr_count;
      tws_master_model_inst.start();
      wr(8'h9a, 1'b1);
      wr(8'h10, 1'b1);
      for (int i = 0; i < 4; i++) begin
         tws_master_model_inst.put_bit(i[0], s);
      end
      tws_master_model_inst.start();
      wr(8'h9a, 1'b1);
      wr(8'h11, 1'b1);
      wr(8'h99, 1'b1);
      tws_master_model_inst.put_bit(1'b0, s);
      tws_master_model_inst.stop();
      check(mem[16], 8'h00);
      check(mem[17], 8'h99);
      check(8'(wr_count - base), 8'h01);
      check({7'h00, busy}, 8'h00);
      $display("t_abort done");
   endtask

   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      reset = 1'b1;
      address_select_pin = 1'b0;
      failures = 0;
      tests_run = 0;
      wr_count = 0;
      rd_count = 0;
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'h00;
      end
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_write();
      t_bad_ptr();
      t_select();
      t_read();
      t_abort();
      give_verdict();
   end

   initial begin
      #200000;
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
